//--- rtl/wsg_pkg.sv
// Package with register map, field layout, reset values and types of the wait generator.
package wsg_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] WAIT_CTRL_ADDR = 8'h00;
    localparam logic [7:0] MEM_BOUNDS_ADDR = 8'h01;
    localparam logic [7:0] STATUS_ADDR = 8'h02;

    // ------------------------------------------------------------------
    // Field layout of wait_control_reg and mem_wait_bounds_reg
    // ------------------------------------------------------------------
    localparam int DAISY_LSB = 6;
    localparam int VECTOR_BIT = 5;
    localparam int OPEXT_BIT = 4;
    localparam int MEMW_LSB = 2;
    localparam int IOW_LSB = 0;
    localparam int HIGH_BOUND_LSB = 4;
    localparam int LOW_BOUND_LSB = 0;

    // ------------------------------------------------------------------
    // Status register bits
    // ------------------------------------------------------------------
    localparam int STAT_POR_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_EXTW_BIT = 2;
    localparam int STAT_SEQ_BIT = 3;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] WAIT_CTRL_RST = 8'hff;
    localparam logic [7:0] WAIT_CTRL_CLR = 8'h00;
    localparam logic [7:0] MEM_BOUNDS_RST = 8'hf0;
    localparam logic [7:0] RET_PREFIX = 8'hed;
    localparam logic [7:0] RET_SECOND = 8'h4d;
    localparam logic [3:0] POR_LAST_FETCH = 4'hf;
    localparam logic [2:0] RET_WAIT_SHORT = 3'h2;
    localparam logic [2:0] RET_WAIT_LONG = 3'h4;
    localparam logic [2:0] RET_WAIT_OTHER = 3'h1;
    localparam logic [2:0] VECTOR_WAITS = 3'h1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic opcode_fetch_cycle_n;
        logic mem_request_n;
        logic io_request_n;
        logic read_n;
        logic write_n;
    } wsg_bus_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_COUNT = 3'h1,
        ST_EXT = 3'h3,
        ST_HOLD = 3'h2,
        ST_ACK_IO = 3'h6
    } wsg_state_t;

    typedef enum logic [2:0] {
        KIND_NONE = 3'h0,
        KIND_FETCH = 3'h1,
        KIND_ACK = 3'h2,
        KIND_MEM = 3'h3,
        KIND_IO = 3'h4
    } wsg_kind_t;

endpackage : wsg_pkg

//--- rtl/wsg_wait_gen.sv
// Wait state generator that stretches bus cycles of the on-chip CPU core.
//
// How it works
// [RL1] The block drives the core's wait request itself, no outside logic needed.
// [RL2] The external wait pin is looked at only after the programmed waits, not after the daisy-chain settle wait.
// [RL3] Memory read and write cycles get zero to three programmed waits.
// [RL4] With the opcode extension set, each opcode fetch gets one more wait on top.
// [RL5] Memory waits apply only inside the programmed address range.
// [RL6] I/O cycles get zero, two, four or six programmed waits.
// [RL7] I/O cycles aimed at on-chip peripheral registers get no I/O waits.
// [RL8] With vector wait set, one wait follows the I/O request in an acknowledge cycle.
// [RL9] An acknowledge cycle gets zero, two, four or six waits before the I/O request falls.
// [RL10] Return-sequence waits are added only for the four or six acknowledge wait settings, in the fetch after EDh.
// [RL11] A 4Dh after EDh gets two waits for the four setting and four for the six setting.
// [RL12] Any other byte after EDh gets exactly one wait.
// [RL13] The control register holds daisy 7-6, vector 5, opcode 4, memory 3-2 and I/O 1-0.
// [RL14] After reset all wait fields sit at maximum until the sixteenth fetch ends, then clear unless written.
// [RL15] Memory waits apply when high bound >= top address nibble >= low bound; bounds reset to F0h.
// [RL16] Waits are whole clock cycles and the request drops exactly when the count is spent.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module wsg_wait_gen #(
    parameter int CNT_W = 3
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [7:0] O_REG_RDATA,
    input wire wsg_pkg::wsg_bus_t I_BUS,
    input wire logic [3:0] I_ADDR_TOP_NIBBLE,
    input wire logic I_ONCHIP_IO,
    input wire logic [7:0] I_DATA,
    input wire logic I_EXT_WAIT_N,
    output logic O_WAIT_N
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Maps a two-bit field onto 0, 2, 4 or 6 waits.
    function automatic logic [CNT_W-1:0] even_waits(input logic [1:0] f);
        even_waits = CNT_W'({f, 1'b0});
    endfunction : even_waits

    function automatic logic [CNT_W-1:0] odd_ext(input logic [1:0] f,
                                                 input logic ext);
        odd_ext = CNT_W'(f) + CNT_W'(ext);
    endfunction : odd_ext

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0] wait_control_reg, wait_control_next;
    logic [7:0] mem_wait_bounds_reg, mem_wait_bounds_next;
    logic ctrl_written_reg, ctrl_written_next;
    logic por_active_reg, por_active_next;
    logic [3:0] fetch_cnt_reg, fetch_cnt_next;
    logic fetch_n_d_reg, fetch_n_d_next;
    logic [7:0] rdata_reg, rdata_next;
    logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
    logic ext_wait_reg, ext_wait_next;
    wsg_pkg::wsg_state_t state_reg, state_next;
    wsg_pkg::wsg_kind_t kind_reg, kind_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic ret_pending_reg, ret_pending_next;
    logic ret_fetch_reg, ret_fetch_next;
    logic prev_prefix_reg, prev_prefix_next;
    logic wait_n_reg, wait_n_next;

    logic [1:0] daisy_f, memw_f, iow_f;
    logic vector_en, opext_en, in_range, ret_armed;
    logic fetch_n_rise;

    assign daisy_f = wait_control_reg[wsg_pkg::DAISY_LSB +: 2];
    assign memw_f = wait_control_reg[wsg_pkg::MEMW_LSB +: 2];
    assign iow_f = wait_control_reg[wsg_pkg::IOW_LSB +: 2];
    assign vector_en = wait_control_reg[wsg_pkg::VECTOR_BIT];
    assign opext_en = wait_control_reg[wsg_pkg::OPEXT_BIT];

    // [RL15] Range compare.
    assign in_range =
        (mem_wait_bounds_reg[wsg_pkg::HIGH_BOUND_LSB +: 4]
         >= I_ADDR_TOP_NIBBLE) &&
        (I_ADDR_TOP_NIBBLE >= mem_wait_bounds_reg[wsg_pkg::LOW_BOUND_LSB +: 4]);

    // [RL10] Only the four or six settings arm the sequence.
    assign ret_armed = daisy_f[1];
    assign fetch_n_rise = I_BUS.opcode_fetch_cycle_n & ~fetch_n_d_reg;

    // ------------------------------------------------------------------
    // External wait synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ext_s1_reg <= 1'b1;
            ext_s2_reg <= 1'b1;
            ext_s3_reg <= 1'b1;
        end else begin
            ext_s1_reg <= I_EXT_WAIT_N;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    // A change is taken once the second and third stages agree.
    always_comb begin
        ext_wait_next = ext_wait_reg;
        if (ext_s2_reg == ext_s3_reg) begin
            ext_wait_next = ~ext_s3_reg;
        end
    end

    // ------------------------------------------------------------------
    // Register file and power-on defaults
    // ------------------------------------------------------------------
    always_comb begin
        wait_control_next = wait_control_reg;
        mem_wait_bounds_next = mem_wait_bounds_reg;
        ctrl_written_next = ctrl_written_reg;
        por_active_next = por_active_reg;
        fetch_cnt_next = fetch_cnt_reg;
        fetch_n_d_next = I_BUS.opcode_fetch_cycle_n;
        rdata_next = 8'h00;

        // [RL14] Count fetch trailing edges and drop the defaults on the 16th.
        if (por_active_reg && fetch_n_rise) begin
            fetch_cnt_next = fetch_cnt_reg + 4'h1;
            if (fetch_cnt_reg == wsg_pkg::POR_LAST_FETCH) begin
                por_active_next = 1'b0;
                if (!ctrl_written_reg) begin
                    wait_control_next = wsg_pkg::WAIT_CTRL_CLR;
                end
            end
        end

        // [RL13] Software writes land in the documented fields.
        if (I_REG_WR) begin
            case (I_REG_ADDR)
                wsg_pkg::WAIT_CTRL_ADDR: begin
                    wait_control_next = I_REG_WDATA;
                    ctrl_written_next = 1'b1;
                end
                wsg_pkg::MEM_BOUNDS_ADDR: begin
                    mem_wait_bounds_next = I_REG_WDATA;
                end
                default: begin
                end
            endcase
        end

        if (I_REG_RD) begin
            case (I_REG_ADDR)
                wsg_pkg::WAIT_CTRL_ADDR: begin
                    rdata_next = wait_control_reg;
                end
                wsg_pkg::MEM_BOUNDS_ADDR: begin
                    rdata_next = mem_wait_bounds_reg;
                end
                wsg_pkg::STATUS_ADDR: begin
                    rdata_next[wsg_pkg::STAT_POR_BIT] = por_active_reg;
                    rdata_next[wsg_pkg::STAT_BUSY_BIT] =
                        (state_reg != wsg_pkg::ST_IDLE);
                    rdata_next[wsg_pkg::STAT_EXTW_BIT] = ext_wait_reg;
                    rdata_next[wsg_pkg::STAT_SEQ_BIT] = prev_prefix_reg;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            // [RL14] Maximum settings from reset.
            wait_control_reg <= wsg_pkg::WAIT_CTRL_RST;
            // [RL15] Bounds cover the whole space from reset.
            mem_wait_bounds_reg <= wsg_pkg::MEM_BOUNDS_RST;
            ctrl_written_reg <= 1'b0;
            por_active_reg <= 1'b1;
            fetch_cnt_reg <= 4'h0;
            fetch_n_d_reg <= 1'b1;
            rdata_reg <= 8'h00;
            ext_wait_reg <= 1'b0;
        end else begin
            wait_control_reg <= wait_control_next;
            mem_wait_bounds_reg <= mem_wait_bounds_next;
            ctrl_written_reg <= ctrl_written_next;
            por_active_reg <= por_active_next;
            fetch_cnt_reg <= fetch_cnt_next;
            fetch_n_d_reg <= fetch_n_d_next;
            rdata_reg <= rdata_next;
            ext_wait_reg <= ext_wait_next;
        end
    end

    // ------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------
    // The core holds each strobe until the wait request is released, so a
    // cycle is taken once in IDLE and HOLD waits for the fetch, memory and I/O requests to rise.
    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        cnt_next = cnt_reg;
        ret_pending_next = ret_pending_reg;
        ret_fetch_next = ret_fetch_reg;
        prev_prefix_next = prev_prefix_reg;

        case (state_reg)
            wsg_pkg::ST_IDLE: begin
                ret_fetch_next = 1'b0;
                if (!I_BUS.opcode_fetch_cycle_n && !I_BUS.mem_request_n) begin
                    // [RL4] Opcode fetch adds the extension wait.
                    kind_next = wsg_pkg::KIND_FETCH;
                    state_next = wsg_pkg::ST_COUNT;
                    // [RL5] Memory waits only within range.
                    cnt_next = odd_ext(in_range ? memw_f : 2'b00, opext_en);
                    // [RL10] Fetch right after the prefix byte.
                    ret_pending_next = prev_prefix_reg && ret_armed;
                    ret_fetch_next = prev_prefix_reg;
                end else if (!I_BUS.opcode_fetch_cycle_n &&
                             I_BUS.io_request_n) begin
                    // [RL9] Daisy-chain settle waits ahead of the I/O request.
                    kind_next = wsg_pkg::KIND_ACK;
                    state_next = wsg_pkg::ST_COUNT;
                    cnt_next = even_waits(daisy_f);
                    ret_pending_next = 1'b0;
                end else if (!I_BUS.mem_request_n &&
                             (!I_BUS.read_n || !I_BUS.write_n)) begin
                    // [RL3] Memory read or write waits.
                    kind_next = wsg_pkg::KIND_MEM;
                    state_next = wsg_pkg::ST_COUNT;
                    // [RL5] Memory waits only within range.
                    cnt_next = in_range ? CNT_W'(memw_f) : '0;
                    ret_pending_next = 1'b0;
                end else if (!I_BUS.io_request_n &&
                             I_BUS.opcode_fetch_cycle_n) begin
                    kind_next = wsg_pkg::KIND_IO;
                    state_next = wsg_pkg::ST_COUNT;
                    // [RL7] On-chip registers get no programmed I/O waits.
                    // [RL6] Off-chip I/O gets 0, 2, 4 or 6.
                    cnt_next = I_ONCHIP_IO ? '0 : even_waits(iow_f);
                    ret_pending_next = 1'b0;
                end
            end
            wsg_pkg::ST_COUNT: begin
                // [RL16] One wait per clock until the count is spent.
                if (cnt_reg > CNT_W'(1)) begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end else if (ret_pending_reg) begin
                    ret_pending_next = 1'b0;
                    if (I_DATA == wsg_pkg::RET_SECOND) begin
                        // [RL11] Two or four waits for the return byte.
                        cnt_next = daisy_f[0] ? CNT_W'(wsg_pkg::RET_WAIT_LONG)
                                              : CNT_W'(wsg_pkg::RET_WAIT_SHORT);
                    end else begin
                        // [RL12] Exactly one wait for any other byte.
                        cnt_next = CNT_W'(wsg_pkg::RET_WAIT_OTHER);
                    end
                end else if (kind_reg == wsg_pkg::KIND_ACK) begin
                    // [RL2] No external sampling after the settle wait.
                    cnt_next = '0;
                    state_next = wsg_pkg::ST_ACK_IO;
                end else begin
                    cnt_next = '0;
                    state_next = wsg_pkg::ST_EXT;
                end
            end
            wsg_pkg::ST_ACK_IO: begin
                if (!I_BUS.io_request_n) begin
                    kind_next = wsg_pkg::KIND_IO;
                    if (vector_en) begin
                        // [RL8] One vector wait after the I/O request falls.
                        cnt_next = CNT_W'(wsg_pkg::VECTOR_WAITS);
                        state_next = wsg_pkg::ST_COUNT;
                    end else begin
                        state_next = wsg_pkg::ST_EXT;
                    end
                end
            end
            wsg_pkg::ST_EXT: begin
                // [RL2] External wait is honoured only here.
                if (!ext_wait_next) begin
                    state_next = wsg_pkg::ST_HOLD;
                    if (kind_reg == wsg_pkg::KIND_FETCH) begin
                        prev_prefix_next = !ret_fetch_reg &&
                                           (I_DATA == wsg_pkg::RET_PREFIX);
                    end
                end
            end
            wsg_pkg::ST_HOLD: begin
                if (I_BUS.opcode_fetch_cycle_n && I_BUS.mem_request_n &&
                    I_BUS.io_request_n) begin
                    state_next = wsg_pkg::ST_IDLE;
                    kind_next = wsg_pkg::KIND_NONE;
                end
            end
            default: begin
                state_next = wsg_pkg::ST_IDLE;
                kind_next = wsg_pkg::KIND_NONE;
                cnt_next = '0;
            end
        endcase

        // [RL1] Wait request is registered from the count or the synchronised pin.
        wait_n_next = !((state_next == wsg_pkg::ST_COUNT &&
                         cnt_next != '0) ||
                        (state_next == wsg_pkg::ST_EXT && ext_wait_next));
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_reg <= wsg_pkg::ST_IDLE;
            kind_reg <= wsg_pkg::KIND_NONE;
            cnt_reg <= '0;
            ret_pending_reg <= 1'b0;
            ret_fetch_reg <= 1'b0;
            prev_prefix_reg <= 1'b0;
            wait_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            cnt_reg <= cnt_next;
            ret_pending_reg <= ret_pending_next;
            ret_fetch_reg <= ret_fetch_next;
            prev_prefix_reg <= prev_prefix_next;
            wait_n_reg <= wait_n_next;
        end
    end

    assign O_WAIT_N = wait_n_reg;
    assign O_REG_RDATA = rdata_reg;

endmodule : wsg_wait_gen

`default_nettype wire

//--- test/wsg_cpu_model.sv
// Behavioural model of the CPU core that runs bus cycles and counts waits.
`timescale 1ns/100ps
`default_nettype none

module wsg_cpu_model (
    input wire logic i_clk,
    input wire logic i_wait_n,
    output wsg_pkg::wsg_bus_t o_bus,
    output logic [3:0] o_nib,
    output logic o_onchip,
    output logic [7:0] o_data
);
    initial begin
        o_bus = 5'h1f;
        o_nib = 4'h0;
        o_onchip = 1'b0;
        o_data = 8'h00;
    end

    // Strobes are held for seventeen clocks; an acknowledge moves to its I/O request once the wait request is seen high again.
    task automatic cycle(input wsg_pkg::wsg_kind_t kind, input logic [3:0] nib,
        input logic onchip, input logic [7:0] dat, output int w1, output int w2);
        int n;
        w1 = 0;
        w2 = 0;
        @(posedge i_clk);
        o_nib <= nib;
        o_onchip <= onchip;
        o_data <= dat;
        case (kind)
            wsg_pkg::KIND_FETCH: o_bus <= 5'h05;
            wsg_pkg::KIND_MEM: o_bus <= 5'h15;
            wsg_pkg::KIND_IO: o_bus <= 5'h19;
            default: o_bus <= 5'h0f;
        endcase
        for (n = 0; n < 16; n++) begin
            @(posedge i_clk);
            #1;
            if (!i_wait_n) w1++;
            else if (kind == wsg_pkg::KIND_ACK && n > 0) break;
        end
        if (kind == wsg_pkg::KIND_ACK) begin
            o_bus <= 5'h0b;
            for (n = 0; n < 14; n++) begin
                @(posedge i_clk);
                #1;
                if (!i_wait_n) w2++;
            end
        end
        @(posedge i_clk);
        o_bus <= 5'h1f;
        o_data <= ~dat;
    endtask : cycle
endmodule : wsg_cpu_model
`default_nettype wire

//--- test/wsg_wait_gen_properties.sv
// Concurrent checks on the ports of the wait state generator.
`timescale 1ns/100ps
`default_nettype none

module wsg_wait_gen_props (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] O_REG_RDATA,
    input wire wsg_pkg::wsg_bus_t I_BUS,
    input wire logic [3:0] I_ADDR_TOP_NIBBLE,
    input wire logic I_ONCHIP_IO,
    input wire logic I_EXT_WAIT_N,
    input wire logic O_WAIT_N
);
    logic [7:0] ctrl_reg, ctrl_next, bnd_reg, bnd_next;
    logic [3:0] ext_reg, ext_next;
    logic wr_reg, wr_next, quiet, io_go, mem_go, in_rng, ext_hi;

    // ------------------------------------------------------------------
    // Shadow copies of the written registers
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        bnd_next = bnd_reg;
        wr_next = wr_reg;
        ext_next = {ext_reg[2:0], I_EXT_WAIT_N};
        if (I_REG_WR && I_REG_ADDR == wsg_pkg::WAIT_CTRL_ADDR) begin
            ctrl_next = I_REG_WDATA;
            wr_next = 1'b1;
        end
        if (I_REG_WR && I_REG_ADDR == wsg_pkg::MEM_BOUNDS_ADDR) begin
            bnd_next = I_REG_WDATA;
        end
        if (I_SRST) begin
            ctrl_next = wsg_pkg::WAIT_CTRL_RST;
            bnd_next = wsg_pkg::MEM_BOUNDS_RST;
            wr_next = 1'b0;
            ext_next = 4'h0;
        end
    end
    always_ff @(posedge I_CLK) begin
        ctrl_reg <= ctrl_next;
        bnd_reg <= bnd_next;
        wr_reg <= wr_next;
        ext_reg <= ext_next;
    end
    assign quiet = I_BUS.opcode_fetch_cycle_n & I_BUS.mem_request_n
        & I_BUS.io_request_n;
    assign io_go = !I_BUS.io_request_n && I_BUS.opcode_fetch_cycle_n;
    assign mem_go = !I_BUS.mem_request_n && I_BUS.opcode_fetch_cycle_n
        && !I_BUS.read_n;
    assign in_rng = bnd_reg[7:4] >= I_ADDR_TOP_NIBBLE
        && I_ADDR_TOP_NIBBLE >= bnd_reg[3:0];
    assign ext_hi = (&ext_reg) && I_EXT_WAIT_N;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SRST);

    a_rdata_idle: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 8'h00)
        else $error("read data outside the read answer cycle");
    a_ctrl_read: assert property (I_REG_RD && wr_reg && I_REG_ADDR == 8'h00
        |=> O_REG_RDATA == $past(ctrl_reg)) else $error("control read wrong");
    a_bounds_read: assert property (I_REG_RD && I_REG_ADDR == 8'h01
        |=> O_REG_RDATA == $past(bnd_reg)) else $error("bounds read wrong");
    a_no_idle_wait: assert property ($fell(O_WAIT_N) |-> !$past(quiet))
        else $error("wait request without a bus cycle");
    a_mem_three: assert property (mem_go && $past(quiet) && in_rng && wr_reg
        && ctrl_reg[3:2] == 2'b11 && ext_hi |=> !O_WAIT_N [*3] ##1 O_WAIT_N)
        else $error("memory cycle did not get three waits");
    a_mem_outside: assert property (mem_go && $past(quiet) && !in_rng
        && ext_hi |=> O_WAIT_N [*2]) else $error("wait outside memory range");
    a_io_two: assert property (io_go && $past(quiet) && !I_ONCHIP_IO && wr_reg
        && ctrl_reg[1:0] == 2'b01 && ext_hi |=> !O_WAIT_N [*2] ##1 O_WAIT_N)
        else $error("I/O cycle did not get two waits");
    a_onchip_io: assert property (io_go && $past(quiet) && I_ONCHIP_IO
        && ext_hi |=> O_WAIT_N [*3]) else $error("on-chip I/O was stretched");

    c_mem: cover property (mem_go && $past(quiet) && in_rng);
    c_ack: cover property (!I_BUS.opcode_fetch_cycle_n && !I_BUS.io_request_n);
    c_ext: cover property (!I_EXT_WAIT_N && !O_WAIT_N);
endmodule : wsg_wait_gen_props

bind wsg_wait_gen wsg_wait_gen_props i_wsg_wait_gen_props (.I_CLK(I_CLK),
    .I_SRST(I_SRST), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
    .I_BUS(I_BUS), .I_ADDR_TOP_NIBBLE(I_ADDR_TOP_NIBBLE),
    .I_ONCHIP_IO(I_ONCHIP_IO), .I_EXT_WAIT_N(I_EXT_WAIT_N),
    .O_WAIT_N(O_WAIT_N));
`default_nettype wire

//--- test/wsg_wait_gen_tb_top.sv
// Self-checking testbench of the wait state generator.
`timescale 1ns/100ps
`default_nettype none

module wsg_wait_gen_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ext_n = 1'b1;
    logic [7:0] rdata, dat;
    logic [3:0] nib;
    logic wait_n, onchip;
    wsg_pkg::wsg_bus_t bus_s;
    int num_errors = 0;
    int samples_checked = 0;

    always #4 clk = ~clk;

    wsg_wait_gen i_wsg_wait_gen (.I_CLK(clk), .I_SRST(srst),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd),
        .O_REG_RDATA(rdata), .I_BUS(bus_s), .I_ADDR_TOP_NIBBLE(nib),
        .I_ONCHIP_IO(onchip), .I_DATA(dat), .I_EXT_WAIT_N(ext_n),
        .O_WAIT_N(wait_n));
    wsg_cpu_model i_wsg_cpu_model (.i_clk(clk), .i_wait_n(wait_n),
        .o_bus(bus_s), .o_nib(nib), .o_onchip(onchip), .o_data(dat));

    task automatic end_of_test;
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            num_errors++;
            $display("[FAIL] %0t waits %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk8(rdata, exp);
    endtask : reg_rd

    task automatic cyc(input wsg_pkg::wsg_kind_t k, input logic [3:0] n,
        input logic o, input logic [7:0] d, input int e1, input int e2);
        int w1, w2;
        i_wsg_cpu_model.cycle(k, n, o, d, w1, w2);
        chk_cnt(w1, e1);
        chk_cnt(w2, e2);
    endtask : cyc

    task automatic t_reset_por;
        reg_rd(wsg_pkg::STATUS_ADDR, 8'h01);
        reg_rd(wsg_pkg::WAIT_CTRL_ADDR, 8'hff);
        reg_rd(wsg_pkg::MEM_BOUNDS_ADDR, 8'hf0);
        reg_wr(8'h07, 8'h55);
        reg_rd(8'h07, 8'h00);
        repeat (15) cyc(wsg_pkg::KIND_FETCH, 4'h3, 1'b0, 8'h00, 4, 0);
        reg_rd(wsg_pkg::WAIT_CTRL_ADDR, 8'hff);
        cyc(wsg_pkg::KIND_FETCH, 4'h3, 1'b0, 8'h00, 4, 0);
        reg_rd(wsg_pkg::WAIT_CTRL_ADDR, 8'h00);
    endtask : t_reset_por

    task automatic t_mem_io;
        for (int m = 0; m < 4; m++) begin
            reg_wr(8'h00, 8'(m << wsg_pkg::MEMW_LSB));
            cyc(wsg_pkg::KIND_MEM, 4'h3, 1'b0, 8'h00, m, 0);
            reg_wr(8'h00, 8'(8'h10 | (m << wsg_pkg::MEMW_LSB)));
            cyc(wsg_pkg::KIND_FETCH, 4'h3, 1'b0, 8'h00, m + 1, 0);
            reg_wr(8'h00, 8'(m << wsg_pkg::IOW_LSB));
            cyc(wsg_pkg::KIND_IO, 4'h0, 1'b0, 8'h00, 2 * m, 0);
            cyc(wsg_pkg::KIND_IO, 4'h0, 1'b1, 8'h00, 0, 0);
        end
        reg_wr(8'h00, 8'h08);
        reg_wr(wsg_pkg::MEM_BOUNDS_ADDR, 8'h52);
        reg_rd(wsg_pkg::MEM_BOUNDS_ADDR, 8'h52);
        cyc(wsg_pkg::KIND_MEM, 4'h1, 1'b0, 8'h00, 0, 0);
        cyc(wsg_pkg::KIND_MEM, 4'h2, 1'b0, 8'h00, 2, 0);
        cyc(wsg_pkg::KIND_MEM, 4'h5, 1'b0, 8'h00, 2, 0);
        cyc(wsg_pkg::KIND_MEM, 4'h6, 1'b0, 8'h00, 0, 0);
        reg_wr(wsg_pkg::MEM_BOUNDS_ADDR, 8'hf0);
    endtask : t_mem_io

    task automatic t_ack_ret;
        for (int d = 0; d < 8; d++) begin
            reg_wr(8'h00, 8'(d << 5));
            cyc(wsg_pkg::KIND_ACK, 4'h0, 1'b0, 8'h00, 2 * (d >> 1), d & 1);
        end
        for (int d = 1; d < 4; d++) begin
            reg_wr(8'h00, 8'(d << wsg_pkg::DAISY_LSB));
            cyc(wsg_pkg::KIND_FETCH, 4'h3, 1'b0, wsg_pkg::RET_PREFIX, 0, 0);
            cyc(wsg_pkg::KIND_FETCH, 4'h3, 1'b0, wsg_pkg::RET_SECOND,
                (d == 1) ? 0 : 2 * d - 2, 0);
            cyc(wsg_pkg::KIND_FETCH, 4'h3, 1'b0, wsg_pkg::RET_PREFIX, 0, 0);
            cyc(wsg_pkg::KIND_FETCH, 4'h3, 1'b0, 8'h00, (d == 1) ? 0 : 1, 0);
        end
        reg_rd(8'h00, 8'hc0);
    endtask : t_ack_ret

    task automatic t_ext;
        int w1, w2;
        for (int k = 0; k < 2; k++) begin
            reg_wr(8'h00, k ? 8'h40 : 8'h08);
            @(posedge clk);
            ext_n <= 1'b0;
            fork
                i_wsg_cpu_model.cycle(k ? wsg_pkg::KIND_ACK : wsg_pkg::KIND_MEM,
                    4'h3, 1'b0, 8'h00, w1, w2);
                begin
                    repeat (8) @(posedge clk);
                    ext_n <= 1'b1;
                end
            join
            chk_cnt(k ? w1 : int'(w1 > 2), k ? 2 : 1);
            chk_cnt(int'(w2 > 0), k);
        end
    endtask : t_ext

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_reset_por();
        t_mem_io();
        t_ack_ret();
        t_ext();
        end_of_test();
    end

    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule : wsg_wait_gen_tb_top
`default_nettype wire
